// *** design/aic_idle_cmds.sv ***
// Idle, idle immediate, nop and read buffer commands with identify words
//
// Contract
// - Identify word 92 reports master password revision; 0000h/FFFFh mean unsupported.
// - Words 100-103 hold max LBA plus one; top word zero.
// - Word 128 bit 8 is one only when enabled at maximum level.
// - Word 128 bit 5 set when enhanced erase unit supported.
// - Expired count aborts unlock and erase unit until reset.
// - Word 128 bits 3..0 are frozen, locked, enabled, supported.
// - Word 209 gives LBA0 alignment, valid with word 106 bit 13.
// - Word 217 reads 0001h, non-rotating medium.
// - Idle opcode sets busy, enters idle, clears busy, interrupts.
// - Idle with nonzero count enables auto power down, 5 ms units.
// - Idle with zero count disables auto power down.
// - Idle immediate sets busy, enters idle, clears busy, interrupts.
// - NOP always ends aborted.
// - Read buffer returns sector buffer contents as a data-in transfer.
`timescale 1ns/10ps
`default_nettype none
module aic_idle_cmds
    import aic_pkg::*;
#(
    parameter int unsigned APD_UNIT = APD_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    output logic irq,
    output logic lowPower
);

    ////////////////////////////////////////////////////////////////////////
    // Identify word decode
    function automatic logic [15:0] idWord(
        input logic [7:0] sel,
        input logic [15:0] cfg,
        input logic expired,
        input logic [15:0] mpw,
        input logic [47:0] lbaTop,
        input logic [15:0] align
    );
        logic [15:0] w;
        logic lba48;
        w = '0;
        lba48 = cfg[CFG_LBA48];
        unique case (sel)
            ID_MPWREV: w = mpw;
            ID_LBA48_0: w = lba48 ? lbaTop[15:0] : 16'h0000;
            ID_LBA48_1: w = lba48 ? lbaTop[31:16] : 16'h0000;
            ID_LBA48_2: w = lba48 ? lbaTop[47:32] : 16'h0000;
            ID_LBA48_3: w = 16'h0000;
            ID_SECTSIZE: w[ID_MULTI_BIT] = cfg[CFG_MULTI];
            ID_SECSTAT: begin
                w[8] = cfg[CFG_EN] & cfg[CFG_LVLMAX];
                w[5] = cfg[CFG_ENH];
                w[4] = expired;
                w[3] = cfg[CFG_FROZEN];
                w[2] = cfg[CFG_LOCK];
                w[1] = cfg[CFG_EN];
                w[0] = cfg[CFG_SUP];
            end
            ID_ALIGN: w = cfg[CFG_MULTI] ? align : 16'h0000;
            ID_ROTATE: w = ROTATE_NONE;
            default: w = '0;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    aic_cmd_e state_q, state_d;
    aic_pwr_e pwr_q, pwr_d;
    logic [7:0] op_q, op_d;
    logic err_q, err_d;
    logic [7:0] seccnt_q, seccnt_d;
    logic [7:0] devhead_q, devhead_d;
    logic apdEn_q, apdEn_d;
    logic [7:0] apdTimeout_q, apdTimeout_d;
    logic [PRE_W-1:0] preCnt_q, preCnt_d;
    logic [7:0] unitCnt_q, unitCnt_d;
    logic [BUF_AW-1:0] rdPtr_q, rdPtr_d;
    logic [BUF_AW-1:0] fillPtr_q, fillPtr_d;
    logic [INT_W-1:0] intStat_q, intStat_d;
    logic [INT_W-1:0] intMask_q, intMask_d;
    logic expired_q, expired_d;
    logic [15:0] secCfg_q, secCfg_d;
    logic [15:0] mpwRev_q, mpwRev_d;
    logic [47:0] maxLba_q, maxLba_d;
    logic [15:0] align_q, align_d;
    logic [7:0] idSel_q, idSel_d;
    logic [DATA_W-1:0] rdData_q, rdData_d;
    logic rdMem_q, rdMem_d;

    logic cmdGo, dataRead, memWe, tick, unitDone;
    logic [INT_W-1:0] events;
    logic [BUF_AW-1:0] memAddr;
    logic [DATA_W-1:0] memRdata, idw, statusVal;
    logic [47:0] lbaTop;

    // Unused task-file fields are simply not stored
    assign cmdGo = regWr && regAddr == REG_CMD && state_q == CMD_READY
        && devhead_q[DH_DRV_BIT] == secCfg_q[CFG_DRV];
    assign dataRead = regRd && regAddr == REG_DATA && state_q == CMD_XFER;
    assign memWe = regWr && regAddr == REG_BUFW;
    assign memAddr = memWe ? fillPtr_q : rdPtr_q;
    assign tick = preCnt_q == PRE_W'(APD_UNIT - 1);
    assign unitDone = tick && (unitCnt_q + 8'h01) == apdTimeout_q;
    assign lbaTop = maxLba_q + 48'h1;
    assign idw = idWord(idSel_q, secCfg_q, expired_q, mpwRev_q, lbaTop,
        align_q);
    assign statusVal = {8'h00, state_q == CMD_EXEC, pwr_q != PWR_STANDBY,
        2'b00, state_q == CMD_XFER, 2'b00, err_q};

    aic_sector_buf u_buf (
        .clk(clk),
        .resetn(resetn),
        .we(memWe),
        .addr(memAddr),
        .wdata(regWdata),
        .rdata(memRdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command and power sequencing
    always_comb begin
        state_d = state_q;
        pwr_d = pwr_q;
        op_d = op_q;
        err_d = err_q;
        apdEn_d = apdEn_q;
        apdTimeout_d = apdTimeout_q;
        preCnt_d = preCnt_q;
        unitCnt_d = unitCnt_q;
        rdPtr_d = rdPtr_q;
        events = '0;
        // Power-down timer runs only while the drive sits waiting
        if (apdEn_q && pwr_q != PWR_STANDBY && state_q == CMD_READY) begin
            preCnt_d = tick ? '0 : preCnt_q + PRE_W'(1);
            if (unitDone) begin
                pwr_d = PWR_STANDBY;
                events[INT_LOWPWR] = 1'b1;
                unitCnt_d = '0;
            end else if (tick) begin
                unitCnt_d = unitCnt_q + 8'h01;
            end
        end
        unique case (state_q)
            CMD_READY: begin
                if (cmdGo) begin
                    op_d = regWdata[7:0];
                    err_d = 1'b0;
                    state_d = CMD_EXEC;
                    preCnt_d = '0;
                    unitCnt_d = '0;
                    if (pwr_q == PWR_STANDBY) begin
                        pwr_d = PWR_ACTIVE;
                    end
                end
            end
            CMD_EXEC: begin
                state_d = CMD_READY;
                unique case (op_q)
                    OP_IDLE_A, OP_IDLE_B: begin
                        pwr_d = PWR_IDLE;
                        apdEn_d = seccnt_q != 8'h00;
                        apdTimeout_d = seccnt_q;
                        events[INT_DONE] = 1'b1;
                    end
                    OP_IMMED_A, OP_IMMED_B: begin
                        pwr_d = PWR_IDLE;
                        events[INT_DONE] = 1'b1;
                    end
                    OP_RDBUF: begin
                        state_d = CMD_XFER;
                        rdPtr_d = '0;
                        events[INT_DATA] = 1'b1;
                    end
                    OP_SEC_UNLOCK, OP_SEC_ERASE: begin
                        if (expired_q) begin
                            err_d = 1'b1;
                            events[INT_ABORT] = 1'b1;
                        end else begin
                            events[INT_DONE] = 1'b1;
                        end
                    end
                    default: begin
                        // NOP and every opcode not handled here
                        err_d = 1'b1;
                        events[INT_ABORT] = 1'b1;
                    end
                endcase
            end
            CMD_XFER: begin
                if (dataRead) begin
                    rdPtr_d = rdPtr_q + BUF_AW'(1);
                    if (rdPtr_q == '1) begin
                        state_d = CMD_READY;
                    end
                end
            end
            default: state_d = CMD_READY;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= CMD_READY;
            pwr_q <= PWR_ACTIVE;
            op_q <= '0;
            err_q <= 1'b0;
            apdEn_q <= 1'b0;
            apdTimeout_q <= '0;
            preCnt_q <= '0;
            unitCnt_q <= '0;
            rdPtr_q <= '0;
        end else begin
            state_q <= state_d;
            pwr_q <= pwr_d;
            op_q <= op_d;
            err_q <= err_d;
            apdEn_q <= apdEn_d;
            apdTimeout_q <= apdTimeout_d;
            preCnt_q <= preCnt_d;
            unitCnt_q <= unitCnt_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        seccnt_d = seccnt_q;
        devhead_d = devhead_q;
        fillPtr_d = fillPtr_q;
        intMask_d = intMask_q;
        secCfg_d = secCfg_q;
        mpwRev_d = mpwRev_q;
        maxLba_d = maxLba_q;
        align_d = align_q;
        idSel_d = idSel_q;
        // Expired flag can only be set; reset alone clears it
        expired_d = expired_q;
        // Set wins over read-clear
        intStat_d = intStat_q | events;
        if (regRd && regAddr == REG_INTSTAT) begin
            intStat_d = events;
        end
        if (memWe) begin
            fillPtr_d = fillPtr_q + BUF_AW'(1);
        end
        if (regWr) begin
            unique case (regAddr)
                REG_SECCNT: seccnt_d = regWdata[7:0];
                REG_DEVHEAD: devhead_d = regWdata[7:0];
                REG_INTMASK: intMask_d = regWdata[INT_W-1:0];
                REG_SECCFG: begin
                    secCfg_d = regWdata;
                    expired_d = expired_q | regWdata[CFG_EXPIRE];
                end
                REG_MPWREV: mpwRev_d = regWdata;
                REG_MAXLBA0: maxLba_d[15:0] = regWdata;
                REG_MAXLBA1: maxLba_d[31:16] = regWdata;
                REG_MAXLBA2: maxLba_d[47:32] = regWdata;
                REG_ALIGN: align_d = regWdata;
                REG_IDSEL: idSel_d = regWdata[7:0];
                REG_BUFPTR: fillPtr_d = regWdata[BUF_AW-1:0];
                default: ;
            endcase
        end
        rdMem_d = dataRead;
        rdData_d = '0;
        if (regRd) begin
            unique case (regAddr)
                REG_SECCNT: rdData_d = {8'h00, seccnt_q};
                REG_DEVHEAD: rdData_d = {8'h00, devhead_q};
                REG_STATUS: rdData_d = statusVal;
                REG_ERROR: rdData_d = {13'h0000, err_q, 2'b00};
                REG_INTSTAT: rdData_d = {12'h000, intStat_q};
                REG_INTMASK: rdData_d = {12'h000, intMask_q};
                REG_POWER: rdData_d = {apdTimeout_q, 5'h00, apdEn_q, pwr_q};
                REG_SECCFG: rdData_d = secCfg_q;
                REG_MPWREV: rdData_d = mpwRev_q;
                REG_MAXLBA0: rdData_d = maxLba_q[15:0];
                REG_MAXLBA1: rdData_d = maxLba_q[31:16];
                REG_MAXLBA2: rdData_d = maxLba_q[47:32];
                REG_ALIGN: rdData_d = align_q;
                REG_IDSEL: rdData_d = {8'h00, idSel_q};
                REG_IDDATA: rdData_d = idw;
                default: rdData_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seccnt_q <= '0;
            devhead_q <= '0;
            fillPtr_q <= '0;
            intStat_q <= '0;
            intMask_q <= '0;
            expired_q <= 1'b0;
            secCfg_q <= CFG_RESET;
            mpwRev_q <= '0;
            maxLba_q <= '0;
            align_q <= '0;
            idSel_q <= '0;
            rdData_q <= '0;
            rdMem_q <= 1'b0;
        end else begin
            seccnt_q <= seccnt_d;
            devhead_q <= devhead_d;
            fillPtr_q <= fillPtr_d;
            intStat_q <= intStat_d;
            intMask_q <= intMask_d;
            expired_q <= expired_d;
            secCfg_q <= secCfg_d;
            mpwRev_q <= mpwRev_d;
            maxLba_q <= maxLba_d;
            align_q <= align_d;
            idSel_q <= idSel_d;
            rdData_q <= rdData_d;
            rdMem_q <= rdMem_d;
        end
    end

    assign regRdata = rdMem_q ? memRdata : rdData_q;
    assign irq = |(intStat_q & intMask_q);
    assign lowPower = pwr_q == PWR_STANDBY;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic isIdle, isImmed;
    assign isIdle = regWdata[7:0] == OP_IDLE_A || regWdata[7:0] == OP_IDLE_B;
    assign isImmed = regWdata[7:0] == OP_IMMED_A
        || regWdata[7:0] == OP_IMMED_B;

    a_idle_seq: assert property (cmdGo && isIdle |=> statusVal[ST_BSY_BIT]
        ##1 !statusVal[ST_BSY_BIT] && pwr_q == PWR_IDLE
        && intStat_q[INT_DONE])
        else $error("idle command sequence wrong");
    a_apd_on: assert property (cmdGo && isIdle && seccnt_q != 8'h00
        |=> ##1 apdEn_q && apdTimeout_q == $past(seccnt_q, 2))
        else $error("auto power down not enabled");
    a_apd_off: assert property (cmdGo && isIdle && seccnt_q == 8'h00
        |=> ##1 !apdEn_q)
        else $error("auto power down not disabled");
    a_immed_seq: assert property (cmdGo && isImmed |=> statusVal[ST_BSY_BIT]
        ##1 !statusVal[ST_BSY_BIT] && pwr_q == PWR_IDLE
        && apdEn_q == $past(apdEn_q, 2))
        else $error("idle immediate sequence wrong");
    a_nop_abort: assert property (cmdGo && regWdata[7:0] == OP_NOP
        |=> ##1 err_q && intStat_q[INT_ABORT])
        else $error("nop not aborted");
    a_expired_abort: assert property (cmdGo && expired_q
        && regWdata[7:0] == OP_SEC_UNLOCK |=> ##1 err_q)
        else $error("unlock accepted after expiry");
    a_rdbuf_drq: assert property (cmdGo && regWdata[7:0] == OP_RDBUF
        |=> ##1 statusVal[ST_DRQ_BIT] && rdPtr_q == '0)
        else $error("read buffer did not start");
    a_rotate_word: assert property (idSel_q == ID_ROTATE
        |-> idw == ROTATE_NONE)
        else $error("rotation word wrong");
    a_sec_level: assert property (idSel_q == ID_SECSTAT
        |-> idw[8] == (secCfg_q[CFG_EN] && secCfg_q[CFG_LVLMAX]))
        else $error("security level bit wrong");
    a_lba_top: assert property (idSel_q == ID_LBA48_3 |-> idw == 16'h0000)
        else $error("top capacity word not zero");
    a_apd_expire: assert property (unitDone && apdEn_q
        && state_q == CMD_READY && pwr_q != PWR_STANDBY
        |=> lowPower)
        else $error("standby not entered on timeout");

    c_idle: cover property (cmdGo && isIdle ##2 intStat_q[INT_DONE]);
    c_nop: cover property (cmdGo && regWdata[7:0] == OP_NOP ##2 err_q);
    c_rdbuf_end: cover property (dataRead && rdPtr_q == '1);
    c_standby: cover property (pwr_q != PWR_STANDBY ##1 lowPower);

endmodule
`default_nettype wire

// *** design/aic_pkg.sv ***
// Shared constants and types of the idle, nop and buffer command block
package aic_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned APD_UNIT_MS = 5;
    localparam int unsigned APD_UNIT_CYCLES =
        APD_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    // Widths
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned BUF_AW = 8;
    localparam int unsigned PRE_W = 16;

    // Register offsets
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_SECCNT = 5'h01;
    localparam logic [4:0] REG_DEVHEAD = 5'h02;
    localparam logic [4:0] REG_STATUS = 5'h03;
    localparam logic [4:0] REG_ERROR = 5'h04;
    localparam logic [4:0] REG_DATA = 5'h05;
    localparam logic [4:0] REG_BUFW = 5'h06;
    localparam logic [4:0] REG_INTSTAT = 5'h07;
    localparam logic [4:0] REG_INTMASK = 5'h08;
    localparam logic [4:0] REG_POWER = 5'h09;
    localparam logic [4:0] REG_SECCFG = 5'h0a;
    localparam logic [4:0] REG_MPWREV = 5'h0b;
    localparam logic [4:0] REG_MAXLBA0 = 5'h0c;
    localparam logic [4:0] REG_MAXLBA1 = 5'h0d;
    localparam logic [4:0] REG_MAXLBA2 = 5'h0e;
    localparam logic [4:0] REG_ALIGN = 5'h0f;
    localparam logic [4:0] REG_IDSEL = 5'h10;
    localparam logic [4:0] REG_IDDATA = 5'h11;
    localparam logic [4:0] REG_BUFPTR = 5'h12;

    // Opcodes
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'he3;
    localparam logic [7:0] OP_IMMED_A = 8'h95;
    localparam logic [7:0] OP_IMMED_B = 8'he1;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_RDBUF = 8'he4;
    localparam logic [7:0] OP_SEC_UNLOCK = 8'hf2;
    localparam logic [7:0] OP_SEC_ERASE = 8'hf4;

    // Task-file bit positions
    localparam int unsigned ST_BSY_BIT = 7;
    localparam int unsigned ST_DRDY_BIT = 6;
    localparam int unsigned ST_DRQ_BIT = 3;
    localparam int unsigned ST_ERR_BIT = 0;
    localparam int unsigned ERR_ABRT_BIT = 2;
    localparam int unsigned DH_DRV_BIT = 4;

    // Security configuration bits
    localparam int unsigned CFG_SUP = 0;
    localparam int unsigned CFG_EN = 1;
    localparam int unsigned CFG_LOCK = 2;
    localparam int unsigned CFG_FROZEN = 3;
    localparam int unsigned CFG_EXPIRE = 4;
    localparam int unsigned CFG_ENH = 5;
    localparam int unsigned CFG_LVLMAX = 8;
    localparam int unsigned CFG_LBA48 = 9;
    localparam int unsigned CFG_MULTI = 10;
    localparam int unsigned CFG_DRV = 11;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Identify word indices
    localparam logic [7:0] ID_MPWREV = 8'h5c;
    localparam logic [7:0] ID_LBA48_0 = 8'h64;
    localparam logic [7:0] ID_LBA48_1 = 8'h65;
    localparam logic [7:0] ID_LBA48_2 = 8'h66;
    localparam logic [7:0] ID_LBA48_3 = 8'h67;
    localparam logic [7:0] ID_SECTSIZE = 8'h6a;
    localparam logic [7:0] ID_SECSTAT = 8'h80;
    localparam logic [7:0] ID_ALIGN = 8'hd1;
    localparam logic [7:0] ID_ROTATE = 8'hd9;
    localparam int unsigned ID_MULTI_BIT = 13;
    localparam logic [15:0] ROTATE_NONE = 16'h0001;

    // Interrupt status bits
    localparam int unsigned INT_DONE = 0;
    localparam int unsigned INT_DATA = 1;
    localparam int unsigned INT_ABORT = 2;
    localparam int unsigned INT_LOWPWR = 3;
    localparam int unsigned INT_W = 4;

    typedef enum logic [1:0] {
        CMD_READY = 2'b00,
        CMD_EXEC = 2'b01,
        CMD_XFER = 2'b10
    } aic_cmd_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_STANDBY = 2'b10
    } aic_pwr_e;

endpackage

// *** design/aic_sector_buf.sv ***
// Sector buffer memory, one port, registered read data
`timescale 1ns/10ps
`default_nettype none
module aic_sector_buf
    import aic_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [BUF_AW-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [0:(1<<BUF_AW)-1];
    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[addr];
        end
    end

    assign rdata = rdata_q;

endmodule
`default_nettype wire

// *** tb/aic_host_model.sv ***
// Host controller model driving the task-file register port
`timescale 1ns/10ps
`default_nettype none
module aic_host_model
    import aic_pkg::*;
(
    input wire logic clk,
    input wire logic [DATA_W-1:0] regRdata,
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWdata,
    output logic regWr,
    output logic regRd
);
    initial begin
        regAddr = '0;
        regWdata = '0;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // Writes one register for one clock cycle, then drives the inverted data
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// *** tb/ata_idle_nop_identify_cmds_test.sv ***
// Self-checking bench of the idle, nop and buffer command block
`timescale 1ns/10ps
`default_nettype none
module ata_idle_nop_identify_cmds_test
    import aic_pkg::*;
;
    localparam int unsigned UNIT = 4;
    logic clk;
    logic resetn;
    logic [4:0] regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic regWr;
    logic regRd;
    logic irq;
    logic lowPower;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    aic_idle_cmds #(.APD_UNIT(UNIT)) dut (.clk(clk), .resetn(resetn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq),
        .lowPower(lowPower));
    aic_host_model host (.clk(clk), .regRdata(regRdata),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rchk(input string nm, input logic [4:0] a,
                        input logic [15:0] exp);
        logic [15:0] v;
        host.rd(a, v);
        check(nm, v, exp);
    endtask

    task automatic cmd(input logic [7:0] op);
        host.wr(REG_CMD, {8'h00, op});
        repeat (2) @(posedge clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_identify;
        logic [7:0] ids [9] = '{8'h5c, 8'h64, 8'h65, 8'h66, 8'h67,
                                8'h6a, 8'h80, 8'hd1, 8'hd9};
        logic [15:0] exps [9] = '{16'h0001, 16'h0000, 16'h0013, 16'h0000,
            16'h0000, 16'h2000, 16'h012f, 16'h0003, 16'h0001};
        host.wr(REG_MPWREV, 16'h0001);
        // Low word all ones so the plus one carries
        host.wr(REG_MAXLBA0, 16'hffff);
        host.wr(REG_MAXLBA1, 16'h0012);
        host.wr(REG_MAXLBA2, 16'h0000);
        host.wr(REG_ALIGN, 16'h0003);
        host.wr(REG_SECCFG, 16'h072f);
        for (int i = 0; i < 9; i++) begin
            host.wr(REG_IDSEL, {8'h00, ids[i]});
            rchk("identify word", REG_IDDATA, exps[i]);
        end
        host.wr(REG_SECCFG, 16'h072d);
        host.wr(REG_IDSEL, {8'h00, ID_SECSTAT});
        rchk("level bit when disabled", REG_IDDATA, 16'h002d);
        host.wr(REG_SECCFG, 16'h0000);
    endtask

    task automatic t_idle;
        logic [7:0] imm [2] = '{OP_IMMED_A, OP_IMMED_B};
        host.wr(REG_INTMASK, 16'h000f);
        host.wr(REG_DEVHEAD, 16'h00ef);
        host.wr(REG_SECCNT, 16'h0002);
        cmd(OP_IDLE_A);
        rchk("power after idle", REG_POWER, 16'h0205);
        check("irq raised", {15'h0, irq}, 16'h0001);
        rchk("done status", REG_INTSTAT, 16'h0001);
        check("irq cleared", {15'h0, irq}, 16'h0000);
        for (int i = 0; i < 40 && !lowPower; i++) @(posedge clk);
        check("standby on timeout", {15'h0, lowPower}, 16'h0001);
        rchk("standby status", REG_INTSTAT, 16'h0008);
        host.wr(REG_SECCNT, 16'h0000);
        cmd(OP_IDLE_B);
        check("woken by command", {15'h0, lowPower}, 16'h0000);
        rchk("power auto off", REG_POWER, 16'h0001);
        repeat (40) @(posedge clk);
        check("no standby", {15'h0, lowPower}, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            host.wr(REG_SECCNT, 16'h0005);
            cmd(imm[i]);
            rchk("power immediate", REG_POWER, 16'h0001);
            rchk("immediate done", REG_INTSTAT, 16'h0001);
        end
        host.wr(REG_DEVHEAD, 16'h0010);
        cmd(OP_IDLE_A);
        rchk("other drive ignored", REG_INTSTAT, 16'h0000);
        host.wr(REG_DEVHEAD, 16'h0000);
    endtask

    task automatic t_rdbuf;
        host.wr(REG_BUFPTR, 16'h0000);
        for (int k = 0; k < 256; k++) host.wr(REG_BUFW, {8'ha5, 8'(k)});
        cmd(OP_RDBUF);
        rchk("transfer status", REG_STATUS, 16'h0048);
        rchk("data ready", REG_INTSTAT, 16'h0002);
        for (int k = 0; k < 256; k++) begin
            rchk("buffer word", REG_DATA, {8'ha5, 8'(k)});
        end
        rchk("transfer over", REG_STATUS, 16'h0040);
        rchk("data after end", REG_DATA, 16'h0000);
    endtask

    task automatic t_abort;
        logic [7:0] sec [2] = '{OP_SEC_UNLOCK, OP_SEC_ERASE};
        cmd(OP_NOP);
        rchk("nop status", REG_STATUS, 16'h0041);
        rchk("nop error", REG_ERROR, 16'h0004);
        rchk("nop aborted", REG_INTSTAT, 16'h0004);
        host.wr(REG_SECCFG, 16'h0010);
        for (int i = 0; i < 2; i++) begin
            cmd(sec[i]);
            rchk("expired abort", REG_INTSTAT, 16'h0004);
        end
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk("expiry cleared", REG_SECCFG, 16'h0000);
        cmd(OP_SEC_UNLOCK);
        rchk("unlock after reset", REG_INTSTAT, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rchk("status after reset", REG_STATUS, 16'h0040);
        t_identify();
        t_idle();
        t_rdbuf();
        t_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
